// ---- hdl/mts_pkg.sv ----
package mts_pkg;

  // ----------------------------------------------------------------
  // Widths and lengths
  // ----------------------------------------------------------------
  localparam int unsigned LEN_W = 16;
  localparam logic [15:0] LEN_MAX = 16'hFFFF;

  // ----------------------------------------------------------------
  // Transmit size bins, inclusive bounds in bytes
  // ----------------------------------------------------------------
  localparam logic [15:0] BIN_1523_LO = 16'h05F3;
  localparam logic [15:0] BIN_1523_HI = 16'h060C;
  localparam logic [15:0] BIN_1549_LO = 16'h060D;
  localparam logic [15:0] BIN_1549_HI = 16'h07FF;
  localparam logic [15:0] BIN_2048_LO = 16'h0800;
  localparam logic [15:0] BIN_2048_HI = 16'h0FFF;
  localparam logic [15:0] BIN_4096_LO = 16'h1000;
  localparam logic [15:0] BIN_4096_HI = 16'h1FFF;
  localparam logic [15:0] BIN_8192_LO = 16'h2000;
  localparam logic [15:0] BIN_8192_HI = 16'h23FF;
  localparam logic [15:0] SMALL_LO    = 16'h0000;
  localparam logic [15:0] SMALL_HI    = 16'h003F;
  localparam logic [15:0] LARGE_LO    = 16'h2400;
  localparam logic [15:0] LARGE_HI    = 16'hFFFF;
  localparam logic [15:0] BAD_FCS_MIN = 16'h0040;

  // ----------------------------------------------------------------
  // Receive checksum handling and test pattern
  // ----------------------------------------------------------------
  localparam int unsigned FCS_BYTES    = 4;
  localparam logic [15:0] NO_STRIP_MAX = 16'h0008;
  localparam logic [7:0]  IDLE_CHAR    = 8'h07;
  localparam int unsigned SCR_W        = 58;
  localparam int unsigned SCR_TAP_A    = 38;
  localparam int unsigned SCR_TAP_B    = 57;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        done;
    logic [15:0] len;
    logic        fcs_bad;
    logic        abort;
  } mts_tx_evt_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       sop;
    logic       eop;
  } mts_rx_beat_s;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_PKT,
    RX_DRAIN
  } mts_rx_state_e;

endpackage

// ---- hdl/mts_bin_pulse.sv ----
`timescale 1ns/1ps
`default_nettype none
module mts_bin_pulse #(
  parameter logic [15:0] LO = 16'h0000,
  parameter logic [15:0] HI = 16'hFFFF
) (
  input  wire logic        ref_clk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        hit_in,
  input  wire logic [15:0] len_in,
  output logic             pulse_out
);

  wire in_range = (len_in >= LO) && (len_in <= HI);

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      pulse_out <= 1'b0;
    else
      pulse_out <= hit_in && in_range;
  end

endmodule
`default_nettype wire

// ---- hdl/mts_stats_ctrl.sv ----
// Notes on behaviour
// RULE_01: Pulse bin for 1523..1548 byte transmits.
// RULE_02: Pulse bin for 1549..2047 byte transmits.
// RULE_03: Pulse bin for 2048..4095 byte transmits.
// RULE_04: Pulse bin for 4096..8191 byte transmits.
// RULE_05: Pulse bin for 8192..9215 byte transmits.
// RULE_06: Pulse undersize for transmits below 64 bytes.
// RULE_07: Pulse oversize for transmits above 9215 bytes.
// RULE_08: Pulse bad checksum above 64 bytes.
// RULE_09: Pulse frame error for user aborted packets.
// RULE_10: Local fault level while decoder initialises.
// RULE_11: Flag transmit FIFO under or overflow.
// RULE_12: User resets port after FIFO error.
// RULE_13: Test mode checks scrambled idle pattern.
// RULE_14: User holds receive enable high normally.
// RULE_15: Disable finishes current packet, then stops.
// RULE_16: Disabled receive reports nothing, stays idle.
// RULE_17: Strip checksum only when deletion enabled.
// RULE_18: Never strip packets of eight bytes or fewer.
// RULE_19: User changes deletion only during reset.
// RULE_20: Each increment lasts exactly one cycle.
`timescale 1ns/1ps
`default_nettype none
module mts_stats_ctrl (
  input  wire logic                  ref_clk_in,
  input  wire logic                  sys_rst_in,
  input  wire mts_pkg::mts_tx_evt_s  tx_evt_in,
  input  wire logic                  rx_decoder_init_in,
  input  wire logic                  tx_fifo_underflow_in,
  input  wire logic                  tx_fifo_overflow_in,
  input  wire logic                  rx_test_pattern_in,
  input  wire logic                  rx_enable_in,
  input  wire logic                  rx_delete_fcs_in,
  input  wire mts_pkg::mts_rx_beat_s rx_beat_in,
  output logic                       tx_bin_1523_1548_out,
  output logic                       tx_bin_1549_2047_out,
  output logic                       tx_bin_2048_4095_out,
  output logic                       tx_bin_4096_8191_out,
  output logic                       tx_bin_8192_9215_out,
  output logic                       tx_small_out,
  output logic                       tx_large_out,
  output logic                       tx_bad_fcs_out,
  output logic                       tx_frame_error_out,
  output logic                       tx_local_fault_out,
  output logic                       tx_fifo_error_out,
  output mts_pkg::mts_rx_beat_s      rx_beat_out,
  output logic                       rx_packet_out,
  output logic                       rx_test_error_out
);

  // ----------------------------------------------------------------
  // Transmit statistics
  // ----------------------------------------------------------------

  wire        tx_hit = tx_evt_in.done;
  wire [15:0] tx_len = tx_evt_in.len;

  mts_bin_pulse #(.LO(mts_pkg::BIN_1523_LO), .HI(mts_pkg::BIN_1523_HI)) u_bin_1523 (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .hit_in     (tx_hit),
    .len_in     (tx_len),
    .pulse_out  (tx_bin_1523_1548_out)
  ); // RULE_01
  mts_bin_pulse #(.LO(mts_pkg::BIN_1549_LO), .HI(mts_pkg::BIN_1549_HI)) u_bin_1549 (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .hit_in     (tx_hit),
    .len_in     (tx_len),
    .pulse_out  (tx_bin_1549_2047_out)
  ); // RULE_02
  mts_bin_pulse #(.LO(mts_pkg::BIN_2048_LO), .HI(mts_pkg::BIN_2048_HI)) u_bin_2048 (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .hit_in     (tx_hit),
    .len_in     (tx_len),
    .pulse_out  (tx_bin_2048_4095_out)
  ); // RULE_03
  mts_bin_pulse #(.LO(mts_pkg::BIN_4096_LO), .HI(mts_pkg::BIN_4096_HI)) u_bin_4096 (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .hit_in     (tx_hit),
    .len_in     (tx_len),
    .pulse_out  (tx_bin_4096_8191_out)
  ); // RULE_04
  mts_bin_pulse #(.LO(mts_pkg::BIN_8192_LO), .HI(mts_pkg::BIN_8192_HI)) u_bin_8192 (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .hit_in     (tx_hit),
    .len_in     (tx_len),
    .pulse_out  (tx_bin_8192_9215_out)
  ); // RULE_05
  mts_bin_pulse #(.LO(mts_pkg::SMALL_LO), .HI(mts_pkg::SMALL_HI)) u_bin_small (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .hit_in     (tx_hit),
    .len_in     (tx_len),
    .pulse_out  (tx_small_out)
  ); // RULE_06
  mts_bin_pulse #(.LO(mts_pkg::LARGE_LO), .HI(mts_pkg::LARGE_HI)) u_bin_large (
    .ref_clk_in (ref_clk_in),
    .sys_rst_in (sys_rst_in),
    .hit_in     (tx_hit),
    .len_in     (tx_len),
    .pulse_out  (tx_large_out)
  ); // RULE_07

  wire next_bad_fcs   = tx_hit && tx_evt_in.fcs_bad && (tx_len > mts_pkg::BAD_FCS_MIN); // RULE_08
  wire next_frame_err = tx_hit && tx_evt_in.abort; // RULE_09
  wire fifo_fault     = tx_fifo_underflow_in || tx_fifo_overflow_in;

  // Pulses follow the one-cycle done strobe, so each packet counts once.
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      tx_bad_fcs_out <= 1'b0;
    else
      tx_bad_fcs_out <= next_bad_fcs; // RULE_08 RULE_20
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      tx_frame_error_out <= 1'b0;
    else
      tx_frame_error_out <= next_frame_err; // RULE_09 RULE_20
  end

  // ----------------------------------------------------------------
  // Transmit fault status
  // ----------------------------------------------------------------

  // The fault is a level that tracks the decoder, not an event to be counted.
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      tx_local_fault_out <= 1'b0;
    else
      tx_local_fault_out <= rx_decoder_init_in; // RULE_10
  end

  // The FIFO error is held until reset, since the port cannot recover without one.
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      tx_fifo_error_out <= 1'b0;
    else if (fifo_fault)
      tx_fifo_error_out <= 1'b1; // RULE_11 RULE_12
  end

  // ----------------------------------------------------------------
  // Receive acceptance and checksum removal
  // ----------------------------------------------------------------

  mts_pkg::mts_rx_state_e state;
  mts_pkg::mts_rx_state_e next_state;
  logic [7:0]             dly [mts_pkg::FCS_BYTES];
  logic [3:0]             vld;
  logic [15:0]            len;
  logic                   del_pkt;

  wire rx_open   = rx_enable_in && !rx_test_pattern_in;
  wire start     = (state != mts_pkg::RX_PKT) && rx_beat_in.valid && rx_beat_in.sop
                   && rx_open; // RULE_15 RULE_16
  wire take      = start || ((state == mts_pkg::RX_PKT) && rx_beat_in.valid); // RULE_15
  wire last_in   = take && rx_beat_in.eop;
  wire [15:0] len_in_pkt = start ? 16'h0001
                         : ((len == mts_pkg::LEN_MAX) ? len : len + 16'h0001);
  wire strip     = (start ? rx_delete_fcs_in : del_pkt)
                   && (len_in_pkt > mts_pkg::NO_STRIP_MAX); // RULE_17 RULE_18 RULE_19
  wire drain     = (state == mts_pkg::RX_DRAIN);
  wire shift     = take || drain;
  wire emit      = shift && vld[3];
  wire emit_eop  = (last_in && strip) || (drain && vld[3] && (vld[2:0] == 3'b000));
  wire [3:0] next_vld = (last_in && strip) ? 4'h0
                      : (start ? 4'h1 : {vld[2:0], take});
  wire drain_done = drain && ((vld[2:0] == 3'b000));

  // ----------------------------------------------------------------
  // Receive state machine
  // ----------------------------------------------------------------

  always_comb
  begin
    next_state = state;
    unique case (state)
      mts_pkg::RX_IDLE:
        if (last_in)
          next_state = strip ? mts_pkg::RX_IDLE : mts_pkg::RX_DRAIN;
        else if (start)
          next_state = mts_pkg::RX_PKT;
      mts_pkg::RX_PKT:
        if (last_in)
          next_state = strip ? mts_pkg::RX_IDLE : mts_pkg::RX_DRAIN;
      mts_pkg::RX_DRAIN:
        if (last_in)
          next_state = strip ? mts_pkg::RX_IDLE : mts_pkg::RX_DRAIN;
        else if (start)
          next_state = mts_pkg::RX_PKT;
        else if (drain_done)
          next_state = mts_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      state <= mts_pkg::RX_IDLE;
      vld   <= 4'h0;
      len   <= 16'h0000;
    end
    else
    begin
      state <= next_state;
      if (shift)
        vld <= next_vld;
      if (take)
        len <= len_in_pkt;
    end
  end

  // Deletion is latched per packet, so a change mid-packet cannot split it.
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
      del_pkt <= 1'b0;
    else if (start)
      del_pkt <= rx_delete_fcs_in; // RULE_17 RULE_19
  end

  // ----------------------------------------------------------------
  // Receive delay line
  // ----------------------------------------------------------------

  // Four bytes are held back so that a trailing checksum can be dropped.
  always_ff @(posedge ref_clk_in)
  begin
    if (shift)
    begin
      dly[0] <= rx_beat_in.data;
      for (int i = 1; i < mts_pkg::FCS_BYTES; i++)
        dly[i] <= dly[i-1];
    end
  end

  // ----------------------------------------------------------------
  // Receive output stage
  // ----------------------------------------------------------------

  // The first byte of a packet is the first one after an idle output cycle, with the delay line not full or holding only the first four bytes.
  wire out_first = emit && (vld[2:0] != 3'b111 || len == 16'h0004) && !rx_beat_out.valid;
  wire out_last  = emit && emit_eop;

  // A packet arriving while the previous one still drains would overlap it; the
  // inter-packet gap of the link is relied on to cover the four drain cycles.
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      rx_beat_out   <= '0;
      rx_packet_out <= 1'b0;
    end
    else
    begin
      rx_beat_out.valid <= emit; // RULE_16
      rx_beat_out.data  <= emit ? dly[3] : 8'h00;
      rx_beat_out.sop   <= out_first;
      rx_beat_out.eop   <= out_last; // RULE_17
      rx_packet_out     <= out_last; // RULE_20
    end
  end

  // ----------------------------------------------------------------
  // Receive test pattern check
  // ----------------------------------------------------------------

  logic [mts_pkg::SCR_W-1:0] scr;
  logic [mts_pkg::SCR_W-1:0] next_scr;
  logic [7:0]                descr;

  // Self-synchronising descrambler, bit 0 of the byte first.
  always_comb
  begin
    next_scr = scr;
    descr    = 8'h00;
    for (int b = 0; b < 8; b++)
    begin
      descr[b] = rx_beat_in.data[b] ^ next_scr[mts_pkg::SCR_TAP_A]
                 ^ next_scr[mts_pkg::SCR_TAP_B];
      next_scr = {next_scr[mts_pkg::SCR_W-2:0], rx_beat_in.data[b]};
    end
  end

  wire test_on  = rx_test_pattern_in && rx_enable_in; // RULE_13 RULE_16
  wire test_bad = test_on && rx_beat_in.valid && (descr != mts_pkg::IDLE_CHAR);

  // The first 58 bits after entry flush the descrambler and may flag spuriously.
  always_ff @(posedge ref_clk_in)
  begin
    if (sys_rst_in)
    begin
      scr               <= '0;
      rx_test_error_out <= 1'b0;
    end
    else
    begin
      if (rx_beat_in.valid)
        scr <= next_scr;
      rx_test_error_out <= test_bad; // RULE_13
    end
  end

endmodule
`default_nettype wire

// ---- bench/mts_stats_ctrl_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module mts_stats_ctrl_sva (
  input wire logic                 ref_clk_in,
  input wire logic                 sys_rst_in,
  input wire mts_pkg::mts_tx_evt_s tx_evt_in,
  input wire logic                 rx_decoder_init_in,
  input wire logic                 tx_fifo_underflow_in,
  input wire logic                 tx_fifo_overflow_in,
  input wire logic                 tx_bin_1523_1548_out,
  input wire logic                 tx_small_out,
  input wire logic                 tx_large_out,
  input wire logic                 tx_bad_fcs_out,
  input wire logic                 tx_frame_error_out,
  input wire logic                 tx_local_fault_out,
  input wire logic                 tx_fifo_error_out,
  input wire logic                 rx_packet_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  wire logic        ev = tx_evt_in.done;
  wire logic [15:0] ln = tx_evt_in.len;
  property p_bin; ev && ln inside {[16'h05F3:16'h060C]} |=> tx_bin_1523_1548_out; endproperty
  a_bin: assert property (p_bin) else $error("size bin pulse missed");
  property p_small; ev && ln < 16'h0040 |=> tx_small_out; endproperty
  a_small: assert property (p_small) else $error("undersize pulse missed");
  property p_large; ev && ln > 16'h23FF |=> tx_large_out; endproperty
  a_large: assert property (p_large) else $error("oversize pulse missed");
  property p_bad; tx_bad_fcs_out |-> $past(ev && tx_evt_in.fcs_bad && ln > 16'h0040); endproperty
  a_bad: assert property (p_bad) else $error("bad checksum pulse without cause");
  property p_ferr; ev && tx_evt_in.abort |=> tx_frame_error_out; endproperty
  a_ferr: assert property (p_ferr) else $error("frame error pulse missed");
  property p_idle;
    !ev |=> !(tx_bin_1523_1548_out | tx_small_out | tx_large_out | tx_bad_fcs_out
      | tx_frame_error_out);
  endproperty
  a_idle: assert property (p_idle) else $error("pulse with no packet end");
  property p_lf; tx_local_fault_out != $past(rx_decoder_init_in) |-> $past(sys_rst_in); endproperty
  a_lf: assert property (p_lf) else $error("local fault does not follow decoder");
  property p_fifo; tx_fifo_underflow_in | tx_fifo_overflow_in |=> tx_fifo_error_out [*3]; endproperty
  a_fifo: assert property (p_fifo) else $error("fifo error not held");
  c_large: cover property (tx_large_out);
  c_fifo: cover property (tx_fifo_error_out);
  c_rx: cover property (rx_packet_out);
endmodule
bind mts_stats_ctrl mts_stats_ctrl_sva chk_u (.*);
`default_nettype wire

// ---- bench/mts_user_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mts_user_model (
  input  wire logic       ref_clk_in,
  input  wire logic [8:0] incr_in,
  input  wire logic       fifo_err_in,
  output logic [15:0]     total_out,
  output logic            port_rst_out
);
  logic [3:0] wait_cnt;
  initial
  begin
    total_out = 16'h0000;
    wait_cnt = 4'h0;
    port_rst_out = 1'b0;
  end
  // Sums are kept across port resets, as user counters would be.
  always @(posedge ref_clk_in)
  begin
    total_out <= total_out + 16'($countones(incr_in));
    port_rst_out <= fifo_err_in && wait_cnt == 4'hF;
    wait_cnt <= fifo_err_in ? wait_cnt + 4'h1 : 4'h0;
  end
endmodule
`default_nettype wire

// ---- bench/mts_stats_ctrl_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module mts_stats_ctrl_tb;
  logic                  ref_clk, bench_rst, port_rst, dec_init, underflow, overflow;
  logic                  test_pat, rx_en, del_fcs, lfault, ferr, rx_pkt, test_err;
  logic [8:0]            incr;
  logic [15:0]           total;
  logic [7:0]            last_byte;
  mts_pkg::mts_tx_evt_s  evt;
  mts_pkg::mts_rx_beat_s rx_in, rx_out;
  int                    n_errors, checked, n_out, n_eop, n_pkt, n_terr, n_sop;
  always #5 ref_clk = ~ref_clk;
  mts_stats_ctrl dut_u (.ref_clk_in(ref_clk), .sys_rst_in(bench_rst | port_rst),
    .tx_evt_in(evt), .rx_decoder_init_in(dec_init), .tx_fifo_underflow_in(underflow),
    .tx_fifo_overflow_in(overflow), .rx_test_pattern_in(test_pat), .rx_enable_in(rx_en),
    .rx_delete_fcs_in(del_fcs), .rx_beat_in(rx_in), .tx_bin_1523_1548_out(incr[8]),
    .tx_bin_1549_2047_out(incr[7]), .tx_bin_2048_4095_out(incr[6]),
    .tx_bin_4096_8191_out(incr[5]), .tx_bin_8192_9215_out(incr[4]), .tx_small_out(incr[3]),
    .tx_large_out(incr[2]), .tx_bad_fcs_out(incr[1]), .tx_frame_error_out(incr[0]),
    .tx_local_fault_out(lfault), .tx_fifo_error_out(ferr), .rx_beat_out(rx_out),
    .rx_packet_out(rx_pkt), .rx_test_error_out(test_err));
  mts_user_model mdl_u (.ref_clk_in(ref_clk), .incr_in(incr), .fifo_err_in(ferr),
    .total_out(total), .port_rst_out(port_rst));
  always @(negedge ref_clk)
  begin
    n_out += rx_out.valid;
    n_eop += rx_out.valid & rx_out.eop;
    n_pkt += rx_pkt;
    n_terr += test_err;
    n_sop += rx_out.valid & rx_out.sop;
    if (rx_out.valid) last_byte = rx_out.data;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask
  function automatic logic [8:0] exp_bins(input logic [15:0] n, input logic f, input logic a);
    exp_bins = {n inside {[16'h05F3:16'h060C]}, n inside {[16'h060D:16'h07FF]},
      n inside {[16'h0800:16'h0FFF]}, n inside {[16'h1000:16'h1FFF]},
      n inside {[16'h2000:16'h23FF]}, n < 16'h0040, n > 16'h23FF, f && n > 16'h0040, a};
  endfunction
  task automatic t_tx_bins();
    logic [15:0] lens [16] = '{16'h0000, 16'h003F, 16'h0040, 16'h0041, 16'h05F2, 16'h05F3,
      16'h060C, 16'h060D, 16'h07FF, 16'h0800, 16'h0FFF, 16'h1000, 16'h1FFF, 16'h2000,
      16'h23FF, 16'h2400};
    logic [8:0]  prev;
    logic [15:0] base;
    int          sum;
    base = total;
    sum = 0;
    for (int i = 0; i <= 16; i++)
    begin
      evt <= (i < 16) ? {1'b1, lens[i % 16], ~i[2], i[0]} : '0;
      @(negedge ref_clk);
      if (i > 0) chk(incr, prev, "tx bins");
      prev = (i < 16) ? exp_bins(lens[i % 16], ~i[2], i[0]) : '0;
      sum += $countones(prev);
      @(posedge ref_clk);
    end
    repeat (2) @(negedge ref_clk);
    chk(total - base, sum, "summed pulses");
  endtask
  task automatic t_faults();
    @(posedge ref_clk);
    dec_init <= 1'b1;
    repeat (3) @(posedge ref_clk);
    dec_init <= 1'b0;
    @(negedge ref_clk);
    chk(lfault, 1, "local fault");
    @(negedge ref_clk);
    chk(lfault, 0, "local fault");
    for (int k = 0; k < 2; k++)
    begin
      @(posedge ref_clk);
      {underflow, overflow} <= k ? 2'b10 : 2'b01;
      @(posedge ref_clk);
      {underflow, overflow} <= 2'b00;
      repeat (10) @(negedge ref_clk);
      chk(ferr, 1, "fifo error");
      repeat (12) @(negedge ref_clk);
      chk(ferr, 0, "fifo error after reset");
    end
  endtask
  // Deletion is only changed under reset, so each case starts with a short reset.
  task automatic t_rx(input int n, input logic del, input int off_at, input int exp_n);
    @(posedge ref_clk);
    bench_rst <= 1'b1;
    del_fcs <= del;
    repeat (2) @(posedge ref_clk);
    bench_rst <= 1'b0;
    rx_en <= 1'b1;
    @(posedge ref_clk);
    {n_out, n_eop, n_pkt, n_sop} = '0;
    for (int i = 0; i < n; i++)
    begin
      rx_in <= {1'b1, 8'(i + 16), i == 0, i == n - 1};
      if (i == off_at) rx_en <= 1'b0;
      @(posedge ref_clk);
    end
    rx_in <= '0;
    repeat (8) @(negedge ref_clk);
    chk(n_out, exp_n, "rx bytes");
    chk(n_pkt, exp_n > 0, "rx packets");
    chk(n_eop, exp_n > 0, "rx ends");
    chk(n_sop, exp_n > 0, "rx starts");
    if (exp_n > 0) chk(last_byte, exp_n + 15, "rx last byte");
  endtask
  // Idle bytes are scrambled here; after sixteen bytes of flush none may be flagged,
  // then every scrambled zero byte must be.
  task automatic t_test();
    logic [57:0] st;
    logic [7:0]  sb;
    logic [7:0]  idle;
    st = '0;
    sb = 8'h00;
    idle = mts_pkg::IDLE_CHAR;
    @(posedge ref_clk);
    test_pat <= 1'b1;
    rx_en <= 1'b1;
    {n_out, n_terr} = '0;
    for (int i = 0; i < 72; i++)
    begin
      for (int b = 0; b < 8; b++)
      begin
        sb[b] = ((i < 40) ? idle[b] : 1'b0) ^ st[38] ^ st[57];
        st = {st[56:0], sb[b]};
      end
      rx_in <= {1'b1, sb, i == 0, i == 71};
      if (i == 16) n_terr = 0;
      if (i == 41)
      begin
        chk(n_terr, 0, "test pattern on idle");
        n_terr = 0;
      end
      @(posedge ref_clk);
    end
    rx_in <= '0;
    test_pat <= 1'b0;
    repeat (4) @(negedge ref_clk);
    chk(n_terr, 32, "test pattern errors");
    chk(n_out, 0, "test mode delivery");
  endtask
  task automatic end_sim();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    n_errors++;
    $display("unexpected at %0t: run hung", $time);
    end_sim();
  end
  initial
  begin
    {ref_clk, dec_init, underflow, overflow, test_pat, del_fcs} = '0;
    {bench_rst, rx_en, n_errors, checked, evt, rx_in} = '0;
    bench_rst = 1'b1;
    rx_en = 1'b1;
    repeat (20) @(posedge ref_clk);
    bench_rst <= 1'b0;
    @(posedge ref_clk);
    t_tx_bins();
    t_faults();
    t_rx(10, 1'b1, -1, 6);
    t_rx(10, 1'b0, -1, 10);
    t_rx(8, 1'b1, -1, 8);
    t_rx(9, 1'b1, -1, 5);
    t_rx(12, 1'b0, 3, 12);
    t_rx(12, 1'b0, 0, 0);
    t_test();
    end_sim();
  end
endmodule
`default_nettype wire
